// *** rsc_pin_sync.sv ***
// Constants package and pin synchroniser for the radio state controller
// ----------------------------------------------------------------------
// Summary of operation
// - Main controller selects transmit or receive mode
// - Power-down pin alone switches module on/off
// - No supply in shutdown; config defaults on exit
// - Shutdown tri-states SPI and all GPIO pins
// - Leaving shutdown enters READY with crystal reference
// - READY goes to LOCK, then TX or RX
// - RX and TX swap only through LOCK
// - One TX/RX command sequences through LOCK
// - After activity return READY, then SLEEP
// - READY to STANDBY, contents retained
// - State machine driven by host commands
// ----------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none

package rsc_pkg;
	localparam int GPIO_COUNT = 4;
	localparam int CMD_WIDTH = 3;
	localparam logic [2:0] CMD_NOP = 3'h0;
	localparam logic [2:0] CMD_READY = 3'h1;
	localparam logic [2:0] CMD_LOCK = 3'h2;
	localparam logic [2:0] CMD_TX = 3'h3;
	localparam logic [2:0] CMD_RX = 3'h4;
	localparam logic [2:0] CMD_SLEEP = 3'h5;
	localparam logic [2:0] CMD_STANDBY = 3'h6;
	localparam int CLK_PERIOD_NS = 100;
	localparam int LOCK_SETTLE_NS = 1000;
	localparam int LOCK_CYCLES = (LOCK_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic SYNC_RESET_LEVEL = 1'b1;
	typedef enum logic [2:0] {
		RSC_SHUTDOWN,
		RSC_READY,
		RSC_LOCK,
		RSC_TX,
		RSC_RX,
		RSC_SLEEP,
		RSC_STANDBY
	} rsc_state_t;
endpackage

module rsc_pin_sync (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic pin_in,
	output logic level_out
);
	import rsc_pkg::*;

	logic [2:0] stage_reg;
	logic [2:0] stage_next;
	logic level_reg;
	logic level_next;

	// Change accepted only once second and third stages agree
	always_comb begin
		stage_next = {stage_reg[1:0], pin_in};
		level_next = level_reg;
		if (stage_reg[1] == stage_reg[2]) begin
			level_next = stage_reg[2];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			stage_reg <= {3{SYNC_RESET_LEVEL}};
			level_reg <= SYNC_RESET_LEVEL;
		end else begin
			stage_reg <= stage_next;
			level_reg <= level_next;
		end
	end

	assign level_out = level_reg;
endmodule // rsc_pin_sync

`default_nettype wire

// *** rsc_controller.sv ***
// Radio operating-state controller
`default_nettype none
`timescale 1ns/1ps

module rsc_controller #(
	parameter int LOCK_CYCLES = rsc_pkg::LOCK_CYCLES
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic power_down_pin,
	input wire logic cmd_valid,
	input wire logic [rsc_pkg::CMD_WIDTH-1:0] cmd_code,
	input wire logic activity_done,
	input wire logic spi_miso_data,
	input wire logic spi_miso_drive,
	input wire logic [rsc_pkg::GPIO_COUNT-1:0] gpio_data,
	input wire logic [rsc_pkg::GPIO_COUNT-1:0] gpio_drive,
	output var rsc_pkg::rsc_state_t state,
	output logic tx_enable,
	output logic rx_enable,
	output logic lo_enable,
	output logic crystal_reference_enable,
	output logic supply_on,
	output logic config_reset,
	output logic cmd_rejected,
	output logic spi_miso_out,
	output logic spi_miso_oe,
	output logic [rsc_pkg::GPIO_COUNT-1:0] gpio_out,
	output logic [rsc_pkg::GPIO_COUNT-1:0] gpio_oe
);
	import rsc_pkg::*;

	localparam int CNT_W = $clog2(LOCK_CYCLES + 1);
	localparam logic [CNT_W-1:0] LOCK_LAST = CNT_W'(LOCK_CYCLES - 1);

	// ------------------------------------------------------------
	// Power-down pin synchroniser
	// ------------------------------------------------------------
	logic pd_level;

	rsc_pin_sync u_pd_sync (
		.ref_clk(ref_clk),
		.srst(srst),
		.pin_in(power_down_pin),
		.level_out(pd_level)
	);

	// ------------------------------------------------------------
	// Operating-state machine
	// ------------------------------------------------------------
	rsc_state_t state_reg;
	rsc_state_t state_next;
	rsc_state_t target_reg;
	rsc_state_t target_next;
	logic [CNT_W-1:0] settle_reg;
	logic [CNT_W-1:0] settle_next;
	logic reject_reg;
	logic reject_next;
	logic cfg_reset_reg;
	logic cfg_reset_next;
	logic settled;

	assign settled = (settle_reg == LOCK_LAST);

	always_comb begin
		state_next = state_reg;
		target_next = target_reg;
		settle_next = settle_reg;
		reject_next = 1'b0;
		cfg_reset_next = 1'b0;
		if (pd_level) begin
			// Pin wins over any command; nothing survives shutdown
			state_next = RSC_SHUTDOWN;
			target_next = RSC_LOCK;
			settle_next = '0;
		end else begin
			case (state_reg)
				RSC_SHUTDOWN: begin
					state_next = RSC_READY;
					cfg_reset_next = 1'b1;
				end
				RSC_READY: begin
					if (cmd_valid) begin
						case (cmd_code)
							CMD_LOCK: begin
								state_next = RSC_LOCK;
								target_next = RSC_LOCK;
							end
							CMD_TX: begin
								state_next = RSC_LOCK;
								target_next = RSC_TX;
							end
							CMD_RX: begin
								state_next = RSC_LOCK;
								target_next = RSC_RX;
							end
							CMD_SLEEP: state_next = RSC_SLEEP;
							CMD_STANDBY: state_next = RSC_STANDBY;
							CMD_NOP, CMD_READY: reject_next = 1'b0;
							default: reject_next = 1'b1;
						endcase
					end
					settle_next = '0;
				end
				RSC_LOCK: begin
					if (!settled) begin
						settle_next = settle_reg + CNT_W'(1);
					end
					if (cmd_valid) begin
						case (cmd_code)
							CMD_TX: target_next = RSC_TX;
							CMD_RX: target_next = RSC_RX;
							CMD_LOCK: target_next = RSC_LOCK;
							CMD_READY: state_next = RSC_READY;
							CMD_NOP: reject_next = 1'b0;
							default: reject_next = 1'b1;
						endcase
					end else if (settled && target_reg != RSC_LOCK) begin
						// Synthesiser must settle before the radio is keyed
						state_next = target_reg;
					end
				end
				RSC_TX, RSC_RX: begin
					// Counter restarts so a swap waits the full settle time
					settle_next = '0;
					if (cmd_valid) begin
						case (cmd_code)
							CMD_READY: state_next = RSC_READY;
							CMD_LOCK: begin
								state_next = RSC_LOCK;
								target_next = RSC_LOCK;
							end
							CMD_TX, CMD_RX: begin
								if ((cmd_code == CMD_TX) != (state_reg == RSC_TX)) begin
									// Direction swap re-enters lock; LO stays up
									state_next = RSC_LOCK;
									target_next = (cmd_code == CMD_TX) ? RSC_TX : RSC_RX;
								end
							end
							CMD_NOP: reject_next = 1'b0;
							default: reject_next = 1'b1;
						endcase
					end else if (activity_done) begin
						state_next = RSC_READY;
					end
				end
				RSC_SLEEP, RSC_STANDBY: begin
					if (cmd_valid) begin
						if (cmd_code == CMD_READY) begin
							state_next = RSC_READY;
						end else if (cmd_code != CMD_NOP) begin
							reject_next = 1'b1;
						end
					end
				end
				default: state_next = RSC_SHUTDOWN;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state_reg <= RSC_SHUTDOWN;
			target_reg <= RSC_LOCK;
			settle_reg <= '0;
			reject_reg <= 1'b0;
			cfg_reset_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			target_reg <= target_next;
			settle_reg <= settle_next;
			reject_reg <= reject_next;
			cfg_reset_reg <= cfg_reset_next;
		end
	end

	// ------------------------------------------------------------
	// Mode enables, registered from the next state
	// ------------------------------------------------------------
	logic tx_en_reg;
	logic tx_en_next;
	logic rx_en_reg;
	logic rx_en_next;
	logic lo_en_reg;
	logic lo_en_next;
	logic xo_en_reg;
	logic xo_en_next;
	logic supply_reg;
	logic supply_next;

	always_comb begin
		tx_en_next = (state_next == RSC_TX);
		rx_en_next = (state_next == RSC_RX);
		lo_en_next = (state_next == RSC_LOCK) || tx_en_next || rx_en_next;
		// Sleep and standby drop the reference to save current
		xo_en_next = lo_en_next || (state_next == RSC_READY);
		// Standby keeps supply so FIFO and registers are retained
		supply_next = (state_next != RSC_SHUTDOWN);
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			tx_en_reg <= 1'b0;
			rx_en_reg <= 1'b0;
			lo_en_reg <= 1'b0;
			xo_en_reg <= 1'b0;
			supply_reg <= 1'b0;
		end else begin
			tx_en_reg <= tx_en_next;
			rx_en_reg <= rx_en_next;
			lo_en_reg <= lo_en_next;
			xo_en_reg <= xo_en_next;
			supply_reg <= supply_next;
		end
	end

	// ------------------------------------------------------------
	// Pin drivers, all released during shutdown
	// ------------------------------------------------------------
	logic miso_reg;
	logic miso_next;
	logic miso_oe_reg;
	logic miso_oe_next;
	logic [GPIO_COUNT-1:0] gpio_reg;
	logic [GPIO_COUNT-1:0] gpio_next;
	logic [GPIO_COUNT-1:0] gpio_oe_reg;
	logic [GPIO_COUNT-1:0] gpio_oe_next;

	always_comb begin
		miso_next = spi_miso_data;
		miso_oe_next = spi_miso_drive && supply_next;
	end

	genvar gi;
	generate
		for (gi = 0; gi < GPIO_COUNT; gi++) begin : g_gpio
			always_comb begin
				gpio_next[gi] = gpio_data[gi];
				gpio_oe_next[gi] = gpio_drive[gi] && supply_next;
			end
		end
	endgenerate

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			miso_reg <= 1'b0;
			miso_oe_reg <= 1'b0;
			gpio_reg <= '0;
			gpio_oe_reg <= '0;
		end else begin
			miso_reg <= miso_next;
			miso_oe_reg <= miso_oe_next;
			gpio_reg <= gpio_next;
			gpio_oe_reg <= gpio_oe_next;
		end
	end

	assign state = state_reg;
	assign tx_enable = tx_en_reg;
	assign rx_enable = rx_en_reg;
	assign lo_enable = lo_en_reg;
	assign crystal_reference_enable = xo_en_reg;
	assign supply_on = supply_reg;
	assign config_reset = cfg_reset_reg;
	assign cmd_rejected = reject_reg;
	assign spi_miso_out = miso_reg;
	assign spi_miso_oe = miso_oe_reg;
	assign gpio_out = gpio_reg;
	assign gpio_oe = gpio_oe_reg;
endmodule // rsc_controller

`default_nettype wire

// *** rsc_monitor.sv ***
// Port checker of the radio state controller
`timescale 1ns/1ps
`default_nettype none
module rsc_monitor #(
	parameter int LOCK_CYCLES = 10
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic power_down_pin,
	input wire logic cmd_valid,
	input wire logic [rsc_pkg::CMD_WIDTH-1:0] cmd_code,
	input var rsc_pkg::rsc_state_t state,
	input wire logic tx_enable,
	input wire logic rx_enable,
	input wire logic lo_enable,
	input wire logic crystal_reference_enable,
	input wire logic supply_on,
	input wire logic config_reset,
	input wire logic cmd_rejected,
	input wire logic spi_miso_data,
	input wire logic spi_miso_drive,
	input wire logic [rsc_pkg::GPIO_COUNT-1:0] gpio_data,
	input wire logic [rsc_pkg::GPIO_COUNT-1:0] gpio_drive,
	input wire logic spi_miso_out,
	input wire logic spi_miso_oe,
	input wire logic [rsc_pkg::GPIO_COUNT-1:0] gpio_out,
	input wire logic [rsc_pkg::GPIO_COUNT-1:0] gpio_oe
);
	import rsc_pkg::*;
	// Slack for the step out of LOCK after the settle count; the command is not synchronised
	localparam int LIM = LOCK_CYCLES + 3;
	// Cycles spent in LOCK so far, so settle time is checked for any parameter value
	int lock_cnt;
	always_ff @(posedge ref_clk) begin
		if (srst || state != RSC_LOCK) begin
			lock_cnt <= 0;
		end else begin
			lock_cnt <= lock_cnt + 1;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	en_map_a: assert property (tx_enable == (state == RSC_TX) && rx_enable == (state == RSC_RX))
		else $error("tx or rx enable wrong");
	lo_map_a: assert property (lo_enable == (state inside {RSC_LOCK, RSC_TX, RSC_RX}))
		else $error("lo enable wrong");
	supply_map_a: assert property (supply_on == (state != RSC_SHUTDOWN))
		else $error("supply wrong");
	pins_hiz_a: assert property (state == RSC_SHUTDOWN |-> !spi_miso_oe && gpio_oe == '0)
		else $error("pin driven in shutdown");
	wake_ready_a: assert property (state == RSC_SHUTDOWN ##1 state != RSC_SHUTDOWN |-> state == RSC_READY && config_reset)
		else $error("bad wake up");
	via_lock_a: assert property ($changed(state) && state inside {RSC_TX, RSC_RX} |-> $past(state) == RSC_LOCK)
		else $error("lock skipped");
	low_power_a: assert property ($changed(state) && state inside {RSC_SLEEP, RSC_STANDBY} |-> $past(state) == RSC_READY)
		else $error("low power not from ready");
	bad_cmd_a: assert property (cmd_valid && cmd_code == 3'h7 && state inside {RSC_READY, RSC_LOCK, RSC_TX, RSC_RX}
		|=> cmd_rejected && $stable(state))
		else $error("bad command taken");
	auto_tx_a: assert property (cmd_valid && cmd_code == CMD_TX && state == RSC_READY
		|=> state == RSC_LOCK ##[1:LIM] state == RSC_TX)
		else $error("tx not reached");
	xo_map_a: assert property (crystal_reference_enable ==
		(state inside {RSC_READY, RSC_LOCK, RSC_TX, RSC_RX}))
		else $error("crystal reference enable wrong");
	pin_data_a: assert property (!$past(srst)
		|-> spi_miso_out == $past(spi_miso_data) && gpio_out == $past(gpio_data))
		else $error("pin data not passed");
	pin_drive_a: assert property (!$past(srst) && state != RSC_SHUTDOWN
		|-> spi_miso_oe == $past(spi_miso_drive) && gpio_oe == $past(gpio_drive))
		else $error("pin drive not passed");
	settle_time_a: assert property ($changed(state) && state inside {RSC_TX, RSC_RX}
		|-> lock_cnt >= LOCK_CYCLES)
		else $error("lock left before settle");
	reject_cause_a: assert property (cmd_rejected |-> $past(cmd_valid))
		else $error("reject without command");
	cfg_pulse_a: assert property (config_reset |-> state == RSC_READY && $past(state) == RSC_SHUTDOWN)
		else $error("config reset misplaced");
	pin_down_a: assert property (power_down_pin [*5] |=> state == RSC_SHUTDOWN)
		else $error("no shutdown");
	tx_c: cover property (state == RSC_TX);
	rx_c: cover property (state == RSC_RX);
	rej_c: cover property (cmd_rejected);
endmodule // rsc_monitor
bind rsc_controller rsc_monitor #(.LOCK_CYCLES(LOCK_CYCLES)) i_rsc_monitor (.ref_clk, .srst, .power_down_pin,
	.cmd_valid, .cmd_code, .state, .tx_enable, .rx_enable, .lo_enable, .crystal_reference_enable, .supply_on,
	.config_reset, .cmd_rejected, .spi_miso_data, .spi_miso_drive, .gpio_data, .gpio_drive, .spi_miso_out,
	.spi_miso_oe, .gpio_out, .gpio_oe);
`default_nettype wire

// *** rsc_host_model.sv ***
// Host model: power-down pin and command strobes
`timescale 1ns/1ps
`default_nettype none
module rsc_host_model (
	input wire logic ref_clk,
	output var logic power_down_pin,
	output var logic cmd_valid,
	output var logic [rsc_pkg::CMD_WIDTH-1:0] cmd_code,
	output var logic activity_done
);
	import rsc_pkg::*;
	initial begin
		power_down_pin = 1'b0;
		cmd_valid = 1'b0;
		cmd_code = CMD_NOP;
		activity_done = 1'b0;
	end
	// Code is inverted once released so the last command value is not left on the bus
	task automatic send(input logic [CMD_WIDTH-1:0] c);
		@(posedge ref_clk) #1;
		cmd_valid = 1'b1;
		cmd_code = c;
		@(posedge ref_clk) #1;
		cmd_valid = 1'b0;
		cmd_code = ~c;
	endtask
	task automatic finish_act;
		@(posedge ref_clk) #1;
		activity_done = 1'b1;
		@(posedge ref_clk) #1;
		activity_done = 1'b0;
	endtask
	task automatic set_pin(input logic v);
		@(posedge ref_clk) #1;
		power_down_pin = v;
	endtask
endmodule // rsc_host_model
`default_nettype wire

// *** test_radio_state_controller.sv ***
// Self-checking bench of the radio state controller
`timescale 1ns/1ps
`default_nettype none
module test_radio_state_controller;
	import rsc_pkg::*;
	localparam int LC = 2;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic power_down_pin;
	logic cmd_valid;
	logic activity_done;
	logic [CMD_WIDTH-1:0] cmd_code;
	logic spi_miso_data = 1'b0;
	logic spi_miso_drive = 1'b0;
	logic [GPIO_COUNT-1:0] gpio_data = '0;
	logic [GPIO_COUNT-1:0] gpio_drive = '0;
	rsc_state_t state;
	rsc_state_t last_st = RSC_SHUTDOWN;
	rsc_state_t exp_q[$];
	int error_cnt = 0;
	int n_compared = 0;
	int cyc = 0;
	always #50 ref_clk = ~ref_clk;
	rsc_host_model i_rsc_host_model (.ref_clk, .power_down_pin, .cmd_valid, .cmd_code, .activity_done);
	rsc_controller #(.LOCK_CYCLES(LC)) i_rsc_controller (.ref_clk, .srst, .power_down_pin, .cmd_valid, .cmd_code,
		.activity_done, .spi_miso_data, .spi_miso_drive, .gpio_data, .gpio_drive, .state, .tx_enable(),
		.rx_enable(), .lo_enable(), .crystal_reference_enable(), .supply_on(), .config_reset(), .cmd_rejected(),
		.spi_miso_out(), .spi_miso_oe(), .gpio_out(), .gpio_oe());
	// Pin drive requests stay random so shutdown must override them
	always @(posedge ref_clk) begin
		#1;
		{spi_miso_data, spi_miso_drive, gpio_data, gpio_drive} = 10'($urandom);
		cyc++;
		if (cyc == 500) begin
			$display("Error %0t: timeout", $time);
			error_cnt++;
			final_report();
		end
	end
	always @(posedge ref_clk) begin
		#2;
		if (state !== last_st) begin
			last_st = state;
			n_compared++;
			if (exp_q.size() == 0 || exp_q[0] !== state) begin
				$display("Error %0t: state %0d", $time, state);
				error_cnt++;
			end
			if (exp_q.size() != 0)
				void'(exp_q.pop_front());
		end
	end
	task automatic step(input logic [CMD_WIDTH-1:0] c, input int n);
		i_rsc_host_model.send(c);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic final_report;
		if (exp_q.size() != 0)
			error_cnt++;
		$display("Counts: %0d compared, %0d errors", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		void'($urandom(32'h89544B56));
		repeat (20) @(posedge ref_clk);
		#1 srst = 1'b0;
		exp_q.push_back(RSC_READY);
		repeat (8) @(posedge ref_clk);
		exp_q = {exp_q, RSC_LOCK, RSC_TX};
		step(CMD_TX, LC + 6);
		exp_q = {exp_q, RSC_LOCK, RSC_RX};
		step(CMD_RX, LC + 6);
		step(3'h7, 3);
		step(CMD_SLEEP, 3);
		exp_q.push_back(RSC_READY);
		i_rsc_host_model.finish_act();
		exp_q.push_back(RSC_SLEEP);
		step(CMD_SLEEP, 3);
		step(CMD_TX, 3);
		exp_q = {exp_q, RSC_READY, RSC_STANDBY, RSC_READY};
		step(CMD_READY, 3);
		step(CMD_STANDBY, 3);
		step(CMD_READY, 3);
		exp_q = {exp_q, RSC_LOCK, RSC_RX, RSC_READY};
		step(CMD_RX, LC + 6);
		step(CMD_READY, 3);
		exp_q = {exp_q, RSC_LOCK, RSC_SHUTDOWN};
		step(CMD_LOCK, 3);
		i_rsc_host_model.set_pin(1'b1);
		repeat (8) @(posedge ref_clk);
		exp_q.push_back(RSC_READY);
		i_rsc_host_model.set_pin(1'b0);
		repeat (8) @(posedge ref_clk);
		// Mid-run reset must land in shutdown and wake again
		exp_q = {exp_q, RSC_SHUTDOWN, RSC_READY};
		@(posedge ref_clk) #1 srst = 1'b1;
		repeat (2) @(posedge ref_clk);
		#1 srst = 1'b0;
		repeat (8) @(posedge ref_clk);
		final_report();
	end
endmodule // test_radio_state_controller
`default_nettype wire
